// ### rtl/arc_pkg.sv
// What this block does
// - Forward only when channel function is analog
// - Source selector must pick an analog channel
// - Control mode picks speed, torque or position output
// - Mode bit chooses ramp path or direct
// - Direct path keeps only the input filter
// - Direct result leaves in the same cycle
// - Scale full input span to maximum reference
// - Separate gains for torque, speed, position
// - Separate offsets added after scaling
// - Separate dead bands per reference kind
// - Torque rise and fall ramps limit changes
// - Speed acceleration and deceleration ramps
// - Torque ramps act as rise and fall
// - Per-channel low-pass, zero to 100 ms
// - Defaults: function off, filter 1 ms
// - Settings apply in every control mode on the ramp path, except the ramps, which position mode skips; the direct path keeps only the filter
// - Direct mode samples on interpolation tick
package arc_pkg;
   localparam int SAMPLE_W = 16;
   localparam int REF_W = 24;
   localparam int GAIN_W = 16;
   localparam int FRAC_W = 12;
   localparam int FILT_W = 28;
   localparam int FS_SHIFT = 15;
   localparam int FIFO_DEPTH = 16;
   localparam logic [7:0] FSEL_OFF = 8'h00;
   localparam logic [7:0] FSEL_ANALOG = 8'hFE;
   localparam logic [6:0] FILT_MAX_MS = 7'h64;
   localparam logic [6:0] FILT_DEFAULT_MS = 7'h01;
   localparam int CTRL_TICK_NS = 125000;
   localparam int STEPS_PER_MS = 1000000 / CTRL_TICK_NS;
   localparam logic [7:0] OFS_FSEL0 = 8'h00;
   localparam logic [7:0] OFS_FSEL1 = 8'h04;
   localparam logic [7:0] OFS_SRC = 8'h08;
   localparam logic [7:0] OFS_MODE = 8'h0C;
   localparam logic [7:0] OFS_PATH = 8'h10;
   localparam logic [7:0] OFS_FILT0 = 8'h14;
   localparam logic [7:0] OFS_FILT1 = 8'h18;
   localparam logic [7:0] OFS_GAIN = 8'h1C;
   localparam logic [7:0] OFS_BIAS = 8'h28;
   localparam logic [7:0] OFS_BAND = 8'h34;
   localparam logic [7:0] OFS_TSLEW = 8'h40;
   localparam logic [7:0] OFS_SSLEW = 8'h48;
   localparam logic [7:0] OFS_REF_RB = 8'h50;
   localparam logic [7:0] OFS_LEVEL = 8'h54;
   typedef enum logic [1:0] {
      CTRL_TORQUE = 2'b00,
      CTRL_SPEED = 2'b01,
      CTRL_POSITION = 2'b10
   } ctrl_mode_t;
   typedef enum logic [1:0] {
      SRC_NONE = 2'b00,
      SRC_ANA0 = 2'b01,
      SRC_ANA1 = 2'b10
   } ref_src_t;
   typedef enum logic {
      PATH_RAMP = 1'b0,
      PATH_DIRECT = 1'b1
   } ref_path_t;
   typedef struct packed {
      logic signed [SAMPLE_W-1:0] ch1;
      logic signed [SAMPLE_W-1:0] ch0;
   } sample_pair_t;
endpackage : arc_pkg

// ### rtl/analog_reference_conditioning.sv
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module sample_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r, rp_r;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic ready_r, push, pop;
   assign push = in_valid && ready_r;
   assign pop = out_ready && (cnt_r != '0);
   assign in_ready = ready_r;
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
   assign level = cnt_r;
   always_comb begin
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         ready_r <= 1'b0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         cnt_r <= cnt_nxt;
         // Registered so the ready pin comes straight from a flop
         ready_r <= (cnt_nxt < FULL);
      end
   end
endmodule : sample_fifo

module analog_reference_conditioning
   import arc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic sample_valid,
   input wire sample_pair_t sample_in,
   output logic sample_ready,
   input wire logic cycle_tick,
   input wire logic interp_tick,
   output logic ref_valid,
   output logic signed [REF_W-1:0] speed_ref,
   output logic signed [REF_W-1:0] torque_ref,
   output logic signed [REF_W-1:0] position_ref
);
   function automatic logic [3:0] filt_shift(input logic [6:0] ms);
      int ratio;
      logic [3:0] sh;
      ratio = int'(ms) * STEPS_PER_MS;
      sh = 4'h0;
      for (int i = 0; i < 15; i++) begin
         if ((1 << i) < ratio) begin
            sh = 4'(i + 1);
         end
      end
      return sh;
   endfunction : filt_shift
   function automatic logic signed [FILT_W-1:0] filt_step(
      input logic signed [FILT_W-1:0] y,
      input logic signed [SAMPLE_W-1:0] x,
      input logic [3:0] sh);
      logic signed [FILT_W:0] xe, ye, d, s;
      xe = {x[SAMPLE_W-1], x, {FRAC_W{1'b0}}};
      // Signed variable, so the shift below stays arithmetic
      ye = {y[FILT_W-1], y};
      d = xe - ye;
      s = ye + (d >>> sh);
      return s[FILT_W-1:0];
   endfunction : filt_step
   function automatic logic [6:0] clamp_ms(input logic [31:0] v);
      return (v > 32'(FILT_MAX_MS)) ? FILT_MAX_MS : v[6:0];
   endfunction : clamp_ms
   function automatic logic [1:0] mode_idx(input ctrl_mode_t m);
      case (m)
         CTRL_TORQUE: return 2'h0;
         CTRL_SPEED: return 2'h1;
         default: return 2'h2;
      endcase
   endfunction : mode_idx
   function automatic logic signed [REF_W-1:0] dead_fn(
      input logic signed [REF_W-1:0] x,
      input logic [REF_W-1:0] th);
      logic signed [REF_W:0] xe, mag;
      xe = {x[REF_W-1], x};
      mag = (xe < 0) ? -xe : xe;
      return ($unsigned(mag) < {1'b0, th}) ? '0 : x;
   endfunction : dead_fn
   logic [7:0] fsel_r [2];
   logic [6:0] filt_ms_r [2];
   ref_src_t src_r;
   ctrl_mode_t mode_r;
   ref_path_t path_r;
   logic [GAIN_W-1:0] gain_r [3];
   logic signed [REF_W-1:0] bias_r [3];
   logic [REF_W-1:0] band_r [3];
   logic [REF_W-1:0] tslew_r [2];
   logic [REF_W-1:0] sslew_r [2];
   logic signed [FILT_W-1:0] filt_r [2];
   logic signed [FILT_W-1:0] filt_nxt [2];
   logic signed [REF_W-1:0] ramp_r, ramp_nxt;
   logic signed [REF_W-1:0] speed_ref_r, torque_ref_r, position_ref_r;
   logic ref_valid_r;
   logic [31:0] rdata_r;
   logic fifo_valid, fifo_ready_in, tick, pop, enable;
   sample_pair_t fifo_data;
   logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level;
   logic [1:0] mi;
   logic signed [SAMPLE_W-1:0] sel_filt;
   logic signed [REF_W-1:0] scaled, biased, target, direct_val, out_val;
   logic signed [SAMPLE_W+GAIN_W:0] prod, prod_sh;
   logic [REF_W-1:0] up_step, down_step;
   logic signed [REF_W:0] diff;
   sample_fifo #(.W(2 * SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(sample_valid),
      .in_ready(fifo_ready_in),
      .in_data(sample_in),
      .out_valid(fifo_valid),
      .out_ready(tick),
      .out_data(fifo_data),
      .level(fifo_level)
   );
   assign tick = (path_r == PATH_DIRECT) ? interp_tick : cycle_tick;
   assign pop = tick && fifo_valid;
   // Register writes
   always_ff @(posedge clk) begin
      if (rst) begin
         src_r <= SRC_NONE;
         mode_r <= CTRL_SPEED;
         path_r <= PATH_RAMP;
         for (int i = 0; i < 3; i++) begin
            gain_r[i] <= '0;
            bias_r[i] <= '0;
            band_r[i] <= '0;
         end
         for (int i = 0; i < 2; i++) begin
            fsel_r[i] <= FSEL_OFF;
            filt_ms_r[i] <= FILT_DEFAULT_MS;
            tslew_r[i] <= '0;
            sslew_r[i] <= '0;
         end
      end else if (wr) begin
         case (addr)
            OFS_FSEL0: fsel_r[0] <= wdata[7:0];
            OFS_FSEL1: fsel_r[1] <= wdata[7:0];
            OFS_SRC: src_r <= ref_src_t'(wdata[1:0]);
            OFS_MODE: mode_r <= ctrl_mode_t'(wdata[1:0]);
            OFS_PATH: path_r <= ref_path_t'(wdata[0]);
            // Out-of-range times clamp rather than wrap
            OFS_FILT0: filt_ms_r[0] <= clamp_ms(wdata);
            OFS_FILT1: filt_ms_r[1] <= clamp_ms(wdata);
            OFS_GAIN: gain_r[0] <= wdata[GAIN_W-1:0];
            OFS_GAIN + 8'h04: gain_r[1] <= wdata[GAIN_W-1:0];
            OFS_GAIN + 8'h08: gain_r[2] <= wdata[GAIN_W-1:0];
            OFS_BIAS: bias_r[0] <= wdata[REF_W-1:0];
            OFS_BIAS + 8'h04: bias_r[1] <= wdata[REF_W-1:0];
            OFS_BIAS + 8'h08: bias_r[2] <= wdata[REF_W-1:0];
            OFS_BAND: band_r[0] <= wdata[REF_W-1:0];
            OFS_BAND + 8'h04: band_r[1] <= wdata[REF_W-1:0];
            OFS_BAND + 8'h08: band_r[2] <= wdata[REF_W-1:0];
            OFS_TSLEW: tslew_r[0] <= wdata[REF_W-1:0];
            OFS_TSLEW + 8'h04: tslew_r[1] <= wdata[REF_W-1:0];
            OFS_SSLEW: sslew_r[0] <= wdata[REF_W-1:0];
            OFS_SSLEW + 8'h04: sslew_r[1] <= wdata[REF_W-1:0];
            default: ;
         endcase
      end
   end
   // Register reads, data one cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= '0;
      end else if (rd) begin
         case (addr)
            OFS_FSEL0: rdata_r <= {24'h000000, fsel_r[0]};
            OFS_FSEL1: rdata_r <= {24'h000000, fsel_r[1]};
            OFS_SRC: rdata_r <= {30'h00000000, src_r};
            OFS_MODE: rdata_r <= {30'h00000000, mode_r};
            OFS_PATH: rdata_r <= {31'h00000000, path_r};
            OFS_FILT0: rdata_r <= {25'h0000000, filt_ms_r[0]};
            OFS_FILT1: rdata_r <= {25'h0000000, filt_ms_r[1]};
            OFS_GAIN: rdata_r <= {16'h0000, gain_r[0]};
            OFS_GAIN + 8'h04: rdata_r <= {16'h0000, gain_r[1]};
            OFS_GAIN + 8'h08: rdata_r <= {16'h0000, gain_r[2]};
            OFS_BIAS: rdata_r <= {8'h00, bias_r[0]};
            OFS_BIAS + 8'h04: rdata_r <= {8'h00, bias_r[1]};
            OFS_BIAS + 8'h08: rdata_r <= {8'h00, bias_r[2]};
            OFS_BAND: rdata_r <= {8'h00, band_r[0]};
            OFS_BAND + 8'h04: rdata_r <= {8'h00, band_r[1]};
            OFS_BAND + 8'h08: rdata_r <= {8'h00, band_r[2]};
            OFS_TSLEW: rdata_r <= {8'h00, tslew_r[0]};
            OFS_TSLEW + 8'h04: rdata_r <= {8'h00, tslew_r[1]};
            OFS_SSLEW: rdata_r <= {8'h00, sslew_r[0]};
            OFS_SSLEW + 8'h04: rdata_r <= {8'h00, sslew_r[1]};
            OFS_REF_RB: rdata_r <= {8'h00, ramp_r};
            OFS_LEVEL: rdata_r <= {27'h0000000, fifo_level};
            default: rdata_r <= '0;
         endcase
      end else begin
         rdata_r <= '0;
      end
   end
   // Conditioning chain, evaluated in the pop cycle itself
   always_comb begin
      filt_nxt[0] = filt_step(filt_r[0], fifo_data.ch0,
                              filt_shift(filt_ms_r[0]));
      filt_nxt[1] = filt_step(filt_r[1], fifo_data.ch1,
                              filt_shift(filt_ms_r[1]));
      sel_filt = (src_r == SRC_ANA1) ? filt_nxt[1][FILT_W-1:FRAC_W]
                                     : filt_nxt[0][FILT_W-1:FRAC_W];
      enable = ((src_r == SRC_ANA0) && (fsel_r[0] == FSEL_ANALOG)) ||
               ((src_r == SRC_ANA1) && (fsel_r[1] == FSEL_ANALOG));
      mi = mode_idx(mode_r);
      // Full-scale code maps onto the programmed gain
      prod = sel_filt * $signed({1'b0, gain_r[mi]});
      prod_sh = prod >>> FS_SHIFT;
      scaled = prod_sh[REF_W-1:0];
      biased = scaled + bias_r[mi];
      target = dead_fn(biased, band_r[mi]);
      direct_val = {{(REF_W-SAMPLE_W){sel_filt[SAMPLE_W-1]}}, sel_filt};
      up_step = (mode_r == CTRL_TORQUE) ? tslew_r[0] : sslew_r[0];
      down_step = (mode_r == CTRL_TORQUE) ? tslew_r[1] : sslew_r[1];
      diff = {target[REF_W-1], target} - {ramp_r[REF_W-1], ramp_r};
      // Zero step means no limit, so an unset ramp never freezes
      if (up_step != '0 && diff > $signed({1'b0, up_step})) begin
         ramp_nxt = ramp_r + $signed(up_step);
      end else if (down_step != '0 &&
                   diff < -$signed({1'b0, down_step})) begin
         ramp_nxt = ramp_r - $signed(down_step);
      end else begin
         ramp_nxt = target;
      end
      if (path_r == PATH_DIRECT) begin
         out_val = direct_val;
      end else if (mode_r == CTRL_POSITION) begin
         out_val = target;
      end else begin
         out_val = ramp_nxt;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         filt_r <= '{default: '0};
      end else if (pop) begin
         filt_r <= filt_nxt;
      end
   end
   // Ramp state tracks direct output too, so a path change is bumpless
   always_ff @(posedge clk) begin
      if (rst) begin
         ramp_r <= '0;
      end else if (pop && enable) begin
         ramp_r <= out_val;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         ref_valid_r <= 1'b0;
         speed_ref_r <= '0;
         torque_ref_r <= '0;
         position_ref_r <= '0;
      end else begin
         ref_valid_r <= pop && enable;
         if (pop && enable) begin
            case (mode_r)
               CTRL_TORQUE: torque_ref_r <= out_val;
               CTRL_SPEED: speed_ref_r <= out_val;
               default: position_ref_r <= out_val;
            endcase
         end
      end
   end
   assign rdata = rdata_r;
   assign sample_ready = fifo_ready_in;
   assign ref_valid = ref_valid_r;
   assign speed_ref = speed_ref_r;
   assign torque_ref = torque_ref_r;
   assign position_ref = position_ref_r;
   property p_fsel_gate;
      @(posedge clk) disable iff (rst)
      ref_valid_r |-> $past(src_r == SRC_ANA0 ? fsel_r[0] == FSEL_ANALOG
                                          : fsel_r[1] == FSEL_ANALOG);
   endproperty
   a_fsel_gate: assert property (p_fsel_gate)
      else $error("reference sent without analog function code");
   property p_src_gate;
      @(posedge clk) disable iff (rst)
      (src_r == SRC_NONE) |=> !ref_valid_r;
   endproperty
   a_src_gate: assert property (p_src_gate)
      else $error("reference sent with no analog source");
   property p_mode_route;
      @(posedge clk) disable iff (rst)
      (pop && enable && mode_r == CTRL_SPEED) |=>
         $stable(torque_ref_r) && ref_valid_r;
   endproperty
   a_mode_route: assert property (p_mode_route)
      else $error("speed mode disturbed torque reference");
   property p_direct_pass;
      @(posedge clk) disable iff (rst)
      (pop && enable && path_r == PATH_DIRECT && mode_r == CTRL_SPEED) |=>
         speed_ref_r == $past(direct_val);
   endproperty
   a_direct_pass: assert property (p_direct_pass)
      else $error("direct path output differs from filtered input");
   property p_same_cycle;
      @(posedge clk) disable iff (rst)
      (pop && enable) |=> ref_valid_r ##1 (!ref_valid_r || $past(pop, 1));
   endproperty
   a_same_cycle: assert property (p_same_cycle)
      else $error("reference not handed on in its own cycle");
   property p_defaults;
      @(posedge clk)
      rst |=> fsel_r[0] == FSEL_OFF && fsel_r[1] == FSEL_OFF &&
              filt_ms_r[0] == FILT_DEFAULT_MS &&
              filt_ms_r[1] == FILT_DEFAULT_MS;
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("defaults wrong after reset");
   property p_filt_range;
      @(posedge clk) disable iff (rst)
      filt_ms_r[0] <= FILT_MAX_MS && filt_ms_r[1] <= FILT_MAX_MS;
   endproperty
   a_filt_range: assert property (p_filt_range)
      else $error("filter time above its maximum");
   property p_dead_band;
      @(posedge clk) disable iff (rst)
      (biased < $signed({1'b0, band_r[mi]}) &&
       biased > -$signed({1'b0, band_r[mi]})) |-> target == '0;
   endproperty
   a_dead_band: assert property (p_dead_band)
      else $error("value inside dead band not zeroed");
   property p_torque_rise;
      @(posedge clk) disable iff (rst)
      (pop && enable && path_r == PATH_RAMP && mode_r == CTRL_TORQUE &&
       tslew_r[0] != '0 && diff > $signed({1'b0, tslew_r[0]})) |=>
         torque_ref_r == $past(ramp_r) + $signed($past(tslew_r[0]));
   endproperty
   a_torque_rise: assert property (p_torque_rise)
      else $error("torque rise not limited by its ramp");
   property p_fast_tick;
      @(posedge clk) disable iff (rst)
      (path_r == PATH_DIRECT && !interp_tick) |-> !pop;
   endproperty
   a_fast_tick: assert property (p_fast_tick)
      else $error("direct mode sampled off the interpolation tick");
   c_direct: cover property (@(posedge clk) disable iff (rst)
      pop && enable && path_r == PATH_DIRECT);
   c_ramp_torque: cover property (@(posedge clk) disable iff (rst)
      pop && enable && path_r == PATH_RAMP && mode_r == CTRL_TORQUE);
   c_fifo_full: cover property (@(posedge clk) disable iff (rst)
      !fifo_ready_in ##1 pop);
   c_band_zero: cover property (@(posedge clk) disable iff (rst)
      pop && enable && biased != '0 && target == '0);
endmodule : analog_reference_conditioning

// ### verif/sample_source.sv
`timescale 1ns/1ps
module sample_source
   import arc_pkg::*;
(
   input wire logic clk,
   input wire logic ready,
   output logic valid,
   output sample_pair_t data
);
   int gap = 0;
   initial begin
      valid = 1'b0;
      data = '0;
   end
   // Released lines show the inverse so stale data never looks fresh
   task push(input sample_pair_t d);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      valid <= 1'b1;
      data <= d;
      do
         @(posedge clk);
      while (ready !== 1'b1);
      valid <= 1'b0;
      data <= ~d;
   endtask : push
endmodule : sample_source

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench
   import arc_pkg::*;
   ;
   logic clk, rst, wr, rd, sv, sr, ctk, itk, rv, seen;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   sample_pair_t smp;
   logic signed [REF_W-1:0] spd, trq, pos;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;

   analog_reference_conditioning dut (.clk(clk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sample_valid(sv),
      .sample_in(smp), .sample_ready(sr), .cycle_tick(ctk),
      .interp_tick(itk), .ref_valid(rv), .speed_ref(spd),
      .torque_ref(trq), .position_ref(pos));
   sample_source src (.clk(clk), .ready(sr), .valid(sv), .data(smp));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task summarize();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize

   // Far longer than the whole sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         summarize();
      end
   end

   task check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check

   task reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_wr

   task reg_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, e);
   endtask : reg_chk

   task tick(input logic direct, output logic hit);
      @(posedge clk);
      if (direct)
         itk <= 1'b1;
      else
         ctk <= 1'b1;
      @(posedge clk);
      itk <= 1'b0;
      ctk <= 1'b0;
      hit = 1'b0;
      // Look just after each edge, where the pulse has settled
      repeat (3) begin
         #1;
         if (rv === 1'b1)
            hit = 1'b1;
         @(posedge clk);
      end
   endtask : tick

   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = '0;
      wdata = '0;
      ctk = 1'b0;
      itk = 1'b0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      reg_chk(OFS_FSEL0, 32'h0);
      reg_chk(OFS_FSEL1, 32'h0);
      reg_chk(OFS_FILT0, 32'h1);
      reg_chk(OFS_FILT1, 32'h1);
      reg_chk(8'hF0, 32'h0);
      reg_wr(OFS_FILT0, 32'hC8);
      reg_chk(OFS_FILT0, 32'h64);
      $display("test defaults done");

      reg_wr(OFS_FILT0, 32'h0);
      reg_wr(OFS_FILT1, 32'h0);
      reg_wr(OFS_FSEL0, 32'hFE);
      reg_wr(OFS_FSEL1, 32'hFE);
      reg_wr(OFS_SRC, 32'h1);
      reg_wr(OFS_PATH, 32'h1);
      reg_wr(8'h2C, 32'h5);
      src.gap = 3;
      src.push({16'h0123, 16'hF000});
      src.gap = 0;
      tick(1'b0, seen);
      check(seen, 1'b0);
      reg_chk(OFS_LEVEL, 32'h1);
      tick(1'b1, seen);
      check(seen, 1'b1);
      check({8'h0, spd}, 32'hFFF000);
      reg_wr(OFS_MODE, 32'h0);
      reg_wr(OFS_SRC, 32'h2);
      src.push({16'h0123, 16'hF000});
      tick(1'b1, seen);
      check({8'h0, trq}, 32'h000123);
      reg_wr(OFS_FSEL1, 32'h0);
      src.push({16'h0456, 16'h0});
      tick(1'b1, seen);
      check(seen, 1'b0);
      check({8'h0, trq}, 32'h000123);
      reg_wr(OFS_SRC, 32'h0);
      src.push({16'h0456, 16'h0});
      tick(1'b1, seen);
      check(seen, 1'b0);
      $display("test direct path done");

      reg_wr(OFS_PATH, 32'h0);
      reg_wr(OFS_SRC, 32'h1);
      reg_wr(OFS_MODE, 32'h1);
      reg_wr(8'h20, 32'h4000);
      src.push({16'h0, 16'h1000});
      tick(1'b0, seen);
      check({8'h0, spd}, 32'h000805);
      reg_wr(OFS_MODE, 32'h0);
      reg_wr(OFS_GAIN, 32'h8000);
      src.push({16'h0, 16'h1000});
      tick(1'b0, seen);
      check({8'h0, trq}, 32'h001000);
      reg_wr(OFS_MODE, 32'h2);
      reg_wr(8'h24, 32'h8000);
      reg_wr(8'h30, 32'h3);
      src.push({16'h0, 16'h1000});
      tick(1'b0, seen);
      check({8'h0, pos}, 32'h001003);
      reg_wr(OFS_MODE, 32'h1);
      reg_wr(8'h38, 32'h1000);
      src.push({16'h0, 16'h1000});
      tick(1'b0, seen);
      check({8'h0, spd}, 32'h0);
      $display("test scale offset band done");

      reg_wr(8'h38, 32'h0);
      reg_wr(OFS_SSLEW, 32'h10);
      src.push({16'h0, 16'h1000});
      tick(1'b0, seen);
      check({8'h0, spd}, 32'h000010);
      reg_wr(8'h4C, 32'h4);
      src.push({16'h0, 16'h0});
      tick(1'b0, seen);
      check({8'h0, spd}, 32'h00000C);
      reg_wr(OFS_MODE, 32'h0);
      reg_wr(OFS_TSLEW, 32'h8);
      src.push({16'h0, 16'h1000});
      tick(1'b0, seen);
      check({8'h0, trq}, 32'h000014);
      reg_wr(8'h44, 32'h2);
      src.push({16'h0, 16'h0});
      tick(1'b0, seen);
      check({8'h0, trq}, 32'h000012);
      reg_chk(OFS_REF_RB, 32'h12);
      $display("test ramps done");

      for (int i = 0; i < FIFO_DEPTH; i++)
         src.push({16'h0, 16'(i)});
      reg_chk(OFS_LEVEL, 32'h10);
      check(sr, 1'b0);
      fork
         src.push({16'h0, 16'h0});
      join_none
      repeat (FIFO_DEPTH + 1) tick(1'b0, seen);
      reg_chk(OFS_LEVEL, 32'h0);
      check(sr, 1'b1);
      $display("test buffer fill and drain done");

      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      reg_chk(OFS_FSEL0, 32'h0);
      reg_chk(OFS_FILT1, 32'h1);
      reg_wr(OFS_FSEL0, 32'hFE);
      reg_wr(OFS_SRC, 32'h1);
      reg_wr(OFS_PATH, 32'h1);
      src.push({16'h0, 16'h0800});
      tick(1'b1, seen);
      check({8'h0, spd}, 32'h000100);
      src.push({16'h0, 16'hF800});
      tick(1'b1, seen);
      check({8'h0, spd}, 32'hFFFFE0);
      $display("test mid-run reset and filter done");
      summarize();
   end
endmodule : testbench
